// >>> verif/smd_front_end_assertions.sv
// checker on the serial front end top ports
`timescale 1ns/1ns
module smd_front_end_assertions #(
  parameter WR_CYCLES = 400
) (
  // clock and reset
  input wire core_clk,
  input wire reset,
  // pins, configuration and status
  input wire sclIn,
  input wire sdaIn,
  input wire sdaOut,
  input wire sdaOe,
  input wire rstPinIn,
  input wire rstPullEn,
  input wire [3:0] devAddr,
  input wire [7:0] zoneRights,
  input wire cardMode,
  input wire writeBusy
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (reset);
  reg [16:0] busyCnt_r;
  reg [15:0] riseCnt_r;
  reg sclPrev_r;
  reg oePrev_r;
  reg txOn_r;
  wire rise = sclIn & ~sclPrev_r;
  // carrier rises since the last data line change
  always @(posedge core_clk) begin
    sclPrev_r <= sclIn;
    oePrev_r <= sdaOe;
    busyCnt_r <= writeBusy ? busyCnt_r + 17'h1 : 17'h0;
    if (reset || !rstPinIn) begin
      riseCnt_r <= 16'h0;
      txOn_r <= 1'b0;
    end else begin
      riseCnt_r <= (sdaOe != oePrev_r) ? {15'h0, rise} : riseCnt_r + {15'h0, rise};
      if (cardMode && sdaOe) txOn_r <= 1'b1;
    end
  end
  sequence s_enter;
    $rose(cardMode);
  endsequence
  sequence s_busyEnd;
    $fell(writeBusy);
  endsequence
  property p_openDrain; !sdaOut; endproperty
  a_openDrain: assert property (p_openDrain) else $error("data driven high");
  property p_pullUp; rstPullEn; endproperty
  a_pullUp: assert property (p_pullUp) else $error("pull-up off");
  property p_syncEdge; !cardMode && $changed(sdaOe) |-> !$past(sclIn, 2); endproperty
  a_syncEdge: assert property (p_syncEdge) else $error("output not on clock low");
  property p_etu;
    cardMode && txOn_r && (sdaOe != oePrev_r) |-> riseCnt_r % 372 == 0 && riseCnt_r != 16'h0;
  endproperty
  a_etu: assert property (p_etu) else $error("bit length wrong");
  property p_addrOff;
    !cardMode && devAddr == 4'h0 && $past(devAddr) == 4'h0 && $past(devAddr, 2) == 4'h0
      |-> !sdaOe;
  endproperty
  a_addrOff: assert property (p_addrOff) else $error("answer with address off");
  property p_busyLen; s_busyEnd |-> busyCnt_r == WR_CYCLES; endproperty
  a_busyLen: assert property (p_busyLen) else $error("write cycle length");
  property p_modeSel; s_enter |-> !$past(rstPinIn) || !$past(rstPinIn, 2); endproperty
  a_modeSel: assert property (p_modeSel) else $error("card mode without reset low");
  property p_sticky; cardMode |=> cardMode; endproperty
  a_sticky: assert property (p_sticky) else $error("card mode lost");
endmodule

bind smd_front_end smd_front_end_assertions #(.WR_CYCLES(WR_CYCLES)) u_chk (
  .core_clk(core_clk), .reset(reset), .sclIn(sclIn), .sdaIn(sdaIn), .sdaOut(sdaOut),
  .sdaOe(sdaOe), .rstPinIn(rstPinIn), .rstPullEn(rstPullEn), .devAddr(devAddr),
  .zoneRights(zoneRights), .cardMode(cardMode), .writeBusy(writeBusy));

// >>> verif/smd_front_end_test.sv
// testbench for the serial front end
`timescale 1ns/1ns
`include "smd_defines.vh"
module smd_front_end_test;
  localparam WR = 400;
  logic core_clk = 1'b0;
  logic reset = 1'b1;
  logic sclIn = 1'b1;
  logic hostSda = 1'b1;
  logic rstDrv = 1'b0;
  logic rstVal = 1'b1;
  logic carrier = 1'b0;
  logic [3:0] devAddr = 4'h5;
  logic [7:0] zoneRights = 8'hdf;
  wire sdaIn, sdaOut, sdaOe, rstPinIn, rstPullEn, cardMode, writeBusy;
  int n_fail = 0;
  int n_tests = 0;
  int i;
  logic a1, a2, s;
  logic [7:0] d;
  initial forever #25 core_clk = ~core_clk;
  always @(posedge core_clk) if (carrier) sclIn <= ~sclIn;
  smd_front_end #(.WR_CYCLES(WR)) u_dut (
    .core_clk(core_clk), .reset(reset), .sclIn(sclIn), .sdaIn(sdaIn), .sdaOut(sdaOut),
    .sdaOe(sdaOe), .rstPinIn(rstPinIn), .rstPullEn(rstPullEn), .devAddr(devAddr),
    .zoneRights(zoneRights), .cardMode(cardMode), .writeBusy(writeBusy));
  smd_host_model u_host (.hostSda(hostSda), .rstDrv(rstDrv), .rstVal(rstVal),
    .sdaOe(sdaOe), .rstPullEn(rstPullEn), .sdaIn(sdaIn), .rstPinIn(rstPinIn));
  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task chk(input logic [63:0] seen, input logic [63:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_fail++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task results;
    $display("tests=%0d fails=%0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task cyc(input int n);
    repeat (n) @(posedge core_clk);
  endtask
  task waitSig(input logic busy, input logic lvl);
    int n;
    n = 0;
    while ((busy ? writeBusy : sdaIn) !== lvl && n < 3000) begin
      cyc(1);
      n++;
    end
    if (n == 3000) begin
      chk(1, 0);
      results;
    end
  endtask
  // one serial clock of 20 cycles, 1 MHz
  task bit1(input logic b, output logic seen);
    cyc(5);
    hostSda <= b;
    cyc(5);
    sclIn <= 1'b1;
    cyc(5);
    seen = sdaIn;
    cyc(5);
    sclIn <= 1'b0;
  endtask
  task sendB(input logic [7:0] v, output logic ack);
    for (i = 0; i < 8; i++) bit1(v[7-i], s);
    bit1(1'b1, s);
    ack = ~s;
  endtask
  task xfer(input logic [7:0] cmd, input logic [7:0] adr);
    hostSda <= 1'b1;
    cyc(5);
    sclIn <= 1'b1;
    cyc(5);
    hostSda <= 1'b0;
    cyc(5);
    sclIn <= 1'b0;
    sendB(cmd, a1);
    sendB(adr, a2);
  endtask
  task stop;
    cyc(5);
    hostSda <= 1'b0;
    cyc(5);
    sclIn <= 1'b1;
    cyc(5);
    hostSda <= 1'b1;
    cyc(10);
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task t_reset;
    int hits;
    hits = 0;
    chk({sdaOe, sdaOut, rstPullEn, cardMode, writeBusy}, 5'b00100);
    carrier <= 1'b1;
    for (i = 0; i < 2000; i++) begin
      cyc(1);
      hits += sdaOe;
    end
    carrier <= 1'b0;
    cyc(1);
    sclIn <= 1'b1;
    chk(hits, 0);
    chk({rstPinIn, cardMode}, 2'b10);
    $display("t_reset done");
  endtask
  task t_write;
    xfer(8'h50, 8'h45);
    chk({a1, a2}, 2'b11);
    sendB(8'ha5, a1);
    chk(a1, 1);
    stop;
    chk(writeBusy, 1);
    xfer(8'h50, 8'h46);
    chk(a1, 0);
    stop;
    waitSig(1'b1, 1'b0);
    $display("t_write done");
  endtask
  task t_read;
    xfer(8'h51, 8'h45);
    chk({a1, a2}, 2'b11);
    for (i = 0; i < 8; i++) begin
      bit1(1'b1, s);
      d = {d[6:0], s};
    end
    bit1(1'b1, s);
    chk(d, 8'ha5);
    stop;
    $display("t_read done");
  endtask
  task t_refuse;
    xfer(8'h30, 8'h10);
    chk(a1, 0);
    stop;
    xfer(8'h50, 8'h80);
    chk({a1, a2}, 2'b10);
    stop;
    devAddr <= 4'h0;
    xfer(8'h00, 8'h10);
    chk(a1, 0);
    stop;
    devAddr <= 4'h5;
    $display("t_refuse done");
  endtask
  task t_card;
    logic [63:0] atr;
    int j;
    int k;
    atr = `SMD_ATR_DEFAULT;
    rstDrv <= 1'b1;
    rstVal <= 1'b0;
    cyc(4);
    chk(cardMode, 1);
    carrier <= 1'b1;
    cyc(50);
    rstVal <= 1'b1;
    for (k = 0; k < 8; k++) begin
      waitSig(1'b0, 1'b0);
      cyc(372);
      chk(sdaIn, 0);
      for (j = 0; j < 8; j++) begin
        cyc(744);
        d[j] = sdaIn;
      end
      cyc(744);
      chk({sdaIn, d}, {^atr[63-8*k -: 8], atr[63-8*k -: 8]});
      cyc(744);
      chk(sdaIn, 1);
      cyc(744);
      chk(sdaIn, 1);
    end
    $display("t_card done");
  endtask
  initial begin
    cyc(6);
    reset <= 1'b0;
    cyc(2);
    t_reset;
    t_write;
    t_read;
    t_refuse;
    t_card;
    results;
  end
endmodule

// >>> verif/smd_host_model.sv
// host side lines: wired data line and reset pin with pull-up
`timescale 1ns/1ns
module smd_host_model (
  // host drive
  input wire hostSda,
  input wire rstDrv,
  input wire rstVal,
  // device drive
  input wire sdaOe,
  input wire rstPullEn,
  // resolved lines
  output wire sdaIn,
  output wire rstPinIn
);
  assign sdaIn = hostSda & ~sdaOe;
  assign rstPinIn = rstDrv ? rstVal : rstPullEn;
endmodule

// >>> verilog/smd_defines.vh
// constants shared by the secure memory serial front end
`ifndef SMD_DEFINES_VH
`define SMD_DEFINES_VH

// ----------------------------------------
// clock and timing
// ----------------------------------------
`define SMD_CLK_MHZ 20
`define SMD_WR_TIME_US 5000
`define SMD_WR_CYCLES (`SMD_WR_TIME_US * `SMD_CLK_MHZ)
`define SMD_ETU_CLKS 9'h174
`define SMD_FRAME_BITS 4'hc

// ----------------------------------------
// answer to reset
// ----------------------------------------
`define SMD_ATR_BYTES 4'h8
`define SMD_ATR_DEFAULT 64'h3b_a1_5c_00_12_34_56_78

// ----------------------------------------
// memory layout
// ----------------------------------------
`define SMD_USER_BYTES 256
`define SMD_PAGE_BYTES 16
`define SMD_PW_SETS 8
`define SMD_PW_PER_SET 2
`define SMD_PW_BYTES 3
`define SMD_KEY_SETS 4
`define SMD_KEY_BYTES 8
`define SMD_CFG_BYTES (`SMD_PW_SETS*`SMD_PW_PER_SET*`SMD_PW_BYTES+`SMD_KEY_SETS*`SMD_KEY_BYTES)

// ----------------------------------------
// command byte fields and fifo depth
// ----------------------------------------
`define SMD_CMD_RD_BIT 0
`define SMD_CMD_CFG_BIT 1
`define SMD_FIFO_DEPTH 8

`endif

// >>> verilog/smd_fifo.v
// synchronous fifo with valid/ready on both sides
`timescale 1ns/1ns

module smd_fifo #(
  parameter WIDTH = 8,
  parameter DEPTH = 8,
  parameter AW = 3
) (
  // clock and reset
  input wire core_clk,
  input wire reset,
  input wire clear,
  // fill side
  input wire inVld,
  output wire inRdy,
  input wire [WIDTH-1:0] inData,
  // drain side
  output wire outVld,
  input wire outRdy,
  output wire [WIDTH-1:0] outData
);

  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0] wrPtr_r;
  reg [AW-1:0] rdPtr_r;
  reg [AW:0] count_r;
  wire push;
  wire pop;

  assign inRdy = (count_r != DEPTH[AW:0]);
  assign outVld = (count_r != {(AW+1){1'b0}});
  assign outData = mem[rdPtr_r];
  assign push = inVld & inRdy;
  assign pop = outVld & outRdy;

  always @(posedge core_clk) begin
    if (push) begin
      mem[wrPtr_r] <= inData;
    end
  end

  always @(posedge core_clk) begin
    if (reset || clear) begin
      wrPtr_r <= {AW{1'b0}};
      rdPtr_r <= {AW{1'b0}};
      count_r <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wrPtr_r <= (wrPtr_r == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wrPtr_r + 1'b1;
      end
      if (pop) begin
        rdPtr_r <= (rdPtr_r == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rdPtr_r + 1'b1;
      end
      if (push && !pop) begin
        count_r <= count_r + 1'b1;
      end else if (pop && !push) begin
        count_r <= count_r - 1'b1;
      end
    end
  end

endmodule

// >>> verilog/smd_front_end.v
// secure memory serial front end: card character mode and two-wire port
`timescale 1ns/1ns
`include "smd_defines.vh"

// Function
// - card mode holds each sent bit for 372 carrier clock periods
// - two-wire write bits are captured at the serial clock rising edge
// - two-wire read bits change at the serial clock falling edge
// - reset sequence in card mode sends the eight answer-to-reset bytes
// - no answer-to-reset is ever sent in two-wire mode
// - reset pin pulled high so an open pin means two-wire mode
// - data line is only pulled low or released, never driven high
// - two-wire commands answered only for the own device address, 1 to 15
// - single byte or 16-byte page writes, nonvolatile cycle timed inside
// - user memory split in four 64-byte zones with own access rights
// - two-wire port works with serial clock up to 1 MHz
// - holds eight sets of two 24-bit passwords and four key sets
// - a start condition opens every two-wire command
module smd_front_end #(
  parameter WR_CYCLES = `SMD_WR_CYCLES,
  parameter [63:0] ATR_VALUE = `SMD_ATR_DEFAULT
) (
  // clock and reset
  input wire core_clk,
  input wire reset,
  // serial pins
  input wire sclIn,
  input wire sdaIn,
  output wire sdaOut,
  output wire sdaOe,
  input wire rstPinIn,
  output wire rstPullEn,
  // configuration
  input wire [3:0] devAddr,
  input wire [7:0] zoneRights,
  // status
  output wire cardMode,
  output wire writeBusy
);

  // ----------------------------------------
  // states
  // ----------------------------------------
  localparam ST_IDLE = 3'h0;
  localparam ST_RX = 3'h1;
  localparam ST_ACK = 3'h2;
  localparam ST_TX = 3'h3;
  localparam ST_RACK = 3'h4;
  localparam PH_CMD = 2'h0;
  localparam PH_ADDR = 2'h1;
  localparam PH_DATA = 2'h2;
  localparam [16:0] WR_LAST = WR_CYCLES - 1;
  localparam [7:0] CFG_BYTES = `SMD_CFG_BYTES;

  // ----------------------------------------
  // storage
  // ----------------------------------------
  reg [7:0] userMem [0:`SMD_USER_BYTES-1];
  reg [7:0] cfgMem [0:`SMD_CFG_BYTES-1];
  reg [7:0] pgData [0:`SMD_PAGE_BYTES-1];

  reg sdaOe_r;
  reg sdaOut_r;
  reg rstPull_r;
  reg cardMode_r;
  reg busy_r;
  reg [16:0] busyCnt_r;
  reg sclD_r;
  reg sdaD_r;
  reg rstD_r;
  reg [2:0] twState_r;
  reg [1:0] phase_r;
  reg [3:0] bitCnt_r;
  reg [7:0] shift_r;
  reg isRead_r;
  reg isCfg_r;
  reg ackNow_r;
  reg hostAck_r;
  reg [7:0] addr_r;
  reg [7:0] pgBase_r;
  reg [7:0] txByte_r;
  reg [15:0] pgValid_r;
  reg twiOe_r;
  reg commitReq_r;
  reg [63:0] atrShift_r;
  reg [3:0] atrLeft_r;
  reg [11:0] frame_r;
  reg [3:0] txLeft_r;
  reg [8:0] etuCnt_r;
  reg atrOe_r;
  integer i;

  wire sclRise = sclIn & ~sclD_r;
  wire sclFall = ~sclIn & sclD_r;
  wire startCond = sclIn & sclD_r & sdaD_r & ~sdaIn;
  wire stopCond = sclIn & sclD_r & ~sdaD_r & sdaIn;
  wire [7:0] rxByte = {shift_r[6:0], sdaIn};
  wire cmdRead = rxByte[`SMD_CMD_RD_BIT];
  wire zoneRd = zoneRights[{rxByte[7:6], 1'b0}];
  wire zoneWr = zoneRights[{rxByte[7:6], 1'b1}];
  wire addrOk = isCfg_r ? (rxByte < CFG_BYTES) : (isRead_r ? zoneRd : zoneWr);
  wire [7:0] userRd = zoneRights[{addr_r[7:6], 1'b0}] ? userMem[addr_r] : 8'hff;
  wire [7:0] cfgRd = (addr_r < CFG_BYTES) ? cfgMem[addr_r[6:0]] : 8'hff;
  wire [7:0] rdByte = isCfg_r ? cfgRd : userRd;
  wire atrStart = cardMode_r & rstPinIn & ~rstD_r;
  wire atrAbort = cardMode_r & ~rstPinIn;
  wire etuTick = sclRise & (etuCnt_r == `SMD_ETU_CLKS - 9'h001);
  wire fifoInRdy;
  wire fifoOutVld;
  wire [7:0] fifoOutData;
  wire txIdle = (txLeft_r == 4'h0);

  assign sdaOut = sdaOut_r;
  assign sdaOe = sdaOe_r;
  assign rstPullEn = rstPull_r;
  assign cardMode = cardMode_r;
  assign writeBusy = busy_r;

  // ----------------------------------------
  // pin sampling, mode selection, line driver
  // ----------------------------------------
  always @(posedge core_clk) begin
    if (reset) begin
      sclD_r <= 1'b1;
      sdaD_r <= 1'b1;
      rstD_r <= 1'b1;
      rstPull_r <= 1'b1;
      cardMode_r <= 1'b0;
      sdaOut_r <= 1'b0;
      sdaOe_r <= 1'b0;
    end else begin
      sclD_r <= sclIn;
      sdaD_r <= sdaIn;
      rstD_r <= rstPinIn;
      rstPull_r <= 1'b1;
      sdaOut_r <= 1'b0;
      if (!rstPinIn && twState_r == ST_IDLE) begin
        cardMode_r <= 1'b1;
      end
      sdaOe_r <= cardMode_r ? atrOe_r : twiOe_r;
    end
  end

  // ----------------------------------------
  // two-wire port
  // ----------------------------------------
  always @(posedge core_clk) begin
    if (reset) begin
      twState_r <= ST_IDLE;
      phase_r <= PH_CMD;
      bitCnt_r <= 4'h0;
      shift_r <= 8'h00;
      isRead_r <= 1'b0;
      isCfg_r <= 1'b0;
      ackNow_r <= 1'b0;
      hostAck_r <= 1'b0;
      addr_r <= 8'h00;
      pgBase_r <= 8'h00;
      txByte_r <= 8'hff;
      pgValid_r <= 16'h0000;
      twiOe_r <= 1'b0;
      commitReq_r <= 1'b0;
    end else begin
      commitReq_r <= 1'b0;
      if (cardMode_r) begin
        twState_r <= ST_IDLE;
        twiOe_r <= 1'b0;
      end else if (startCond) begin
        twState_r <= ST_RX;
        phase_r <= PH_CMD;
        bitCnt_r <= 4'h0;
        twiOe_r <= 1'b0;
      end else if (stopCond) begin
        twState_r <= ST_IDLE;
        twiOe_r <= 1'b0;
        if (phase_r == PH_DATA && !isRead_r && pgValid_r != 16'h0000) begin
          commitReq_r <= 1'b1;
        end
      end else begin
        case (twState_r)
          ST_RX: begin
            if (sclRise && bitCnt_r != 4'h8) begin
              shift_r <= rxByte;
              bitCnt_r <= bitCnt_r + 4'h1;
              if (bitCnt_r == 4'h7) begin
                case (phase_r)
                  PH_CMD: begin
                    isRead_r <= cmdRead;
                    isCfg_r <= rxByte[`SMD_CMD_CFG_BIT];
                    ackNow_r <= (rxByte[7:4] == devAddr) && (devAddr != 4'h0) && !busy_r;
                    phase_r <= PH_ADDR;
                  end
                  PH_ADDR: begin
                    addr_r <= rxByte;
                    pgBase_r <= {rxByte[7:4], 4'h0};
                    pgValid_r <= 16'h0000;
                    ackNow_r <= addrOk;
                    phase_r <= PH_DATA;
                  end
                  default: begin
                    pgData[addr_r[3:0]] <= rxByte;
                    pgValid_r[addr_r[3:0]] <= 1'b1;
                    addr_r <= {addr_r[7:4], addr_r[3:0] + 4'h1};
                    ackNow_r <= 1'b1;
                  end
                endcase
              end
            end else if (sclFall && bitCnt_r == 4'h8) begin
              twState_r <= ST_ACK;
              twiOe_r <= ackNow_r;
            end
          end
          ST_ACK: begin
            if (sclFall) begin
              if (!ackNow_r) begin
                twState_r <= ST_IDLE;
                twiOe_r <= 1'b0;
              end else if (isRead_r && phase_r == PH_DATA) begin
                twState_r <= ST_TX;
                txByte_r <= rdByte;
                twiOe_r <= ~rdByte[7];
                bitCnt_r <= 4'h1;
              end else begin
                twState_r <= ST_RX;
                bitCnt_r <= 4'h0;
                twiOe_r <= 1'b0;
              end
            end
          end
          ST_TX: begin
            if (sclFall) begin
              if (bitCnt_r == 4'h8) begin
                twState_r <= ST_RACK;
                twiOe_r <= 1'b0;
              end else begin
                twiOe_r <= ~txByte_r[6];
                txByte_r <= {txByte_r[6:0], 1'b1};
                bitCnt_r <= bitCnt_r + 4'h1;
              end
            end
          end
          ST_RACK: begin
            if (sclRise) begin
              hostAck_r <= ~sdaIn;
              addr_r <= addr_r + 8'h01;
            end else if (sclFall) begin
              if (hostAck_r) begin
                twState_r <= ST_TX;
                txByte_r <= rdByte;
                twiOe_r <= ~rdByte[7];
                bitCnt_r <= 4'h1;
              end else begin
                twState_r <= ST_IDLE;
              end
            end
          end
          default: begin
            twState_r <= ST_IDLE;
          end
        endcase
      end
    end
  end

  // ----------------------------------------
  // nonvolatile commit and write timer
  // ----------------------------------------
  always @(posedge core_clk) begin
    if (reset) begin
      busy_r <= 1'b0;
      busyCnt_r <= 17'h00000;
      for (i = 0; i < `SMD_USER_BYTES; i = i + 1) begin
        userMem[i] <= 8'h00;
      end
      for (i = 0; i < `SMD_CFG_BYTES; i = i + 1) begin
        cfgMem[i] <= 8'h00;
      end
    end else if (commitReq_r && !busy_r) begin
      busy_r <= 1'b1;
      busyCnt_r <= WR_LAST;
      for (i = 0; i < `SMD_PAGE_BYTES; i = i + 1) begin
        if (pgValid_r[i]) begin
          if (isCfg_r) begin
            cfgMem[{pgBase_r[6:4], i[3:0]}] <= pgData[i];
          end else begin
            userMem[{pgBase_r[7:4], i[3:0]}] <= pgData[i];
          end
        end
      end
    end else if (busy_r) begin
      busyCnt_r <= busyCnt_r - 17'h00001;
      if (busyCnt_r == 17'h00000) begin
        busy_r <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // answer-to-reset loader into the fifo
  // ----------------------------------------
  always @(posedge core_clk) begin
    if (reset) begin
      atrShift_r <= 64'h0;
      atrLeft_r <= 4'h0;
    end else if (atrAbort) begin
      atrLeft_r <= 4'h0;
    end else if (atrStart) begin
      atrShift_r <= ATR_VALUE;
      atrLeft_r <= `SMD_ATR_BYTES;
    end else if (atrLeft_r != 4'h0 && fifoInRdy) begin
      atrShift_r <= {atrShift_r[55:0], 8'h00};
      atrLeft_r <= atrLeft_r - 4'h1;
    end
  end

  smd_fifo #(
    .WIDTH(8),
    .DEPTH(`SMD_FIFO_DEPTH),
    .AW(3)
  ) atrFifo (
    .core_clk(core_clk),
    .reset(reset),
    .clear(atrAbort),
    .inVld(atrLeft_r != 4'h0),
    .inRdy(fifoInRdy),
    .inData(atrShift_r[63:56]),
    .outVld(fifoOutVld),
    .outRdy(txIdle & etuTick & cardMode_r & rstPinIn),
    .outData(fifoOutData)
  );

  // ----------------------------------------
  // card mode character transmitter
  // ----------------------------------------
  always @(posedge core_clk) begin
    if (reset) begin
      frame_r <= 12'hfff;
      txLeft_r <= 4'h0;
      etuCnt_r <= 9'h000;
      atrOe_r <= 1'b0;
    end else if (!cardMode_r || atrAbort) begin
      txLeft_r <= 4'h0;
      etuCnt_r <= 9'h000;
      atrOe_r <= 1'b0;
    end else if (txIdle && !etuTick) begin
      etuCnt_r <= etuCnt_r + {8'h00, sclRise}; // idle etus keep start bits on the etu grid
    end else if (txIdle) begin
      etuCnt_r <= 9'h000;
      if (fifoOutVld) begin
        frame_r <= {2'b11, ^fifoOutData, fifoOutData, 1'b0};
        txLeft_r <= `SMD_FRAME_BITS;
        atrOe_r <= 1'b1;
      end
    end else if (sclRise) begin
      if (etuTick) begin
        etuCnt_r <= 9'h000;
        frame_r <= {1'b1, frame_r[11:1]};
        txLeft_r <= txLeft_r - 4'h1;
        atrOe_r <= (txLeft_r == 4'h1) ? 1'b0 : ~frame_r[1];
      end else begin
        etuCnt_r <= etuCnt_r + 9'h001;
      end
    end
  end

endmodule
